// *** dv/clock_source_chk.sv ***
// Purpose: Port-level checks of the clock source block
// Assumes: Fuses only change while reset is high
// Notes: Bound to every instance of the block
`include "clock_source_cfg.svh"
module clock_source_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] clock_select_fuses,
    input wire logic oscillator_option_fuse,
    input wire logic fuses_virgin,
    input wire logic legacy_mode,
    input wire logic [7:0] calibration_byte,
    input wire logic wake_request,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] trim_value,
    input wire logic [2:0] source_sel,
    input wire logic crystal_in_cap_en,
    input wire logic crystal_out_cap_en,
    input wire logic clock_release
);
    logic [1:0] cyc_q;
    logic lf_sel, rc_sel, int_sel, trim_wr, live, ext_sel;
    // ****************
    // Helpers
    // ****************
    // Edges since reset release, saturating; the trim load lands on the first
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_q <= 2'h0;
        end else if (cyc_q != 2'h3) begin
            cyc_q <= cyc_q + 2'h1;
        end
    end
    // Decode of programmed fuses, live from the second edge after reset so the
    // reset values of the registered outputs are not judged; blank fuses apart
    assign live = cyc_q != 2'h0;
    assign lf_sel = live && !fuses_virgin && clock_select_fuses == `SEL_LF_CRYSTAL;
    assign rc_sel = live && !fuses_virgin && clock_select_fuses inside {[4'h5:4'h8]};
    assign int_sel = live && !fuses_virgin && clock_select_fuses inside {[4'h1:4'h4]};
    assign ext_sel = live && !fuses_virgin && clock_select_fuses == `SEL_EXT_CLOCK;
    assign trim_wr = reg_write && reg_addr == `TRIM_OFFSET && cyc_q == 2'h3;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ****************
    // Properties
    // ****************
    property p_lf_src; lf_sel |=> source_sel == clock_source_pkg::SRC_LF_CRYSTAL; endproperty
    a_lf_src: assert property (p_lf_src) else $error("watch crystal not chosen");
    property p_ext_src; ext_sel |=> source_sel == clock_source_pkg::SRC_EXT_CLOCK; endproperty
    a_ext_src: assert property (p_ext_src) else $error("external clock not chosen");
    property p_rc_src; rc_sel |=> source_sel == clock_source_pkg::SRC_EXT_RC; endproperty
    a_rc_src: assert property (p_rc_src) else $error("external rc not chosen");
    property p_int_src; int_sel |=> source_sel == clock_source_pkg::SRC_INT_RC; endproperty
    a_int_src: assert property (p_int_src) else $error("internal rc not chosen");
    property p_dflt_src; fuses_virgin |=> source_sel == clock_source_pkg::SRC_INT_RC; endproperty
    a_dflt_src: assert property (p_dflt_src) else $error("blank fuse default wrong");
    property p_lf_caps; lf_sel && oscillator_option_fuse
        |=> crystal_in_cap_en && crystal_out_cap_en; endproperty
    a_lf_caps: assert property (p_lf_caps) else $error("crystal caps off");
    property p_rc_caps; (rc_sel || ext_sel) && oscillator_option_fuse
        |=> crystal_in_cap_en && !crystal_out_cap_en; endproperty
    a_rc_caps: assert property (p_rc_caps) else $error("input cap wrong");
    property p_cal_load; cyc_q == 2'h1 |-> trim_value == $past(calibration_byte); endproperty
    a_cal_load: assert property (p_cal_load) else $error("calibration not loaded");
    property p_legacy_wr; legacy_mode && trim_wr |=> $stable(trim_value); endproperty
    a_legacy_wr: assert property (p_legacy_wr) else $error("hidden trim written");
    property p_legacy_rd; legacy_mode && reg_read && reg_addr == `TRIM_OFFSET |=> reg_rdata == 8'h00; endproperty
    a_legacy_rd: assert property (p_legacy_rd) else $error("hidden trim readable");
    property p_trim_wr; !legacy_mode && trim_wr |=> trim_value == $past(reg_wdata); endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
    property p_wake_int; int_sel && clock_release && wake_request
        |=> !clock_release [*6] ##[1:4] clock_release; endproperty
    a_wake_int: assert property (p_wake_int) else $error("wake count wrong");
endmodule

bind clock_source_select clock_source_chk u_clock_source_chk (.*);

// *** dv/clock_source_select_tb.sv ***
// Purpose: Self-checking bench of the clock source block
// Assumes: Reset delays shortened to 4 and 8 watchdog ticks
// Notes: Fuses change only while reset is held
`include "clock_source_cfg.svh"
module clock_source_select_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int D4 = 4;
    localparam int D65 = 8;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] clock_select_fuses = 4'h1;
    logic [1:0] startup_time_fuses = 2'h2;
    logic oscillator_option_fuse = 1'b0;
    logic fuses_virgin = 1'b0;
    logic legacy_mode = 1'b0;
    logic [7:0] calibration_byte = 8'h00;
    logic watchdog_osc;
    logic wake_request = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata, trim_value;
    logic [2:0] source_sel;
    logic [1:0] rc_range;
    logic crystal_in_cap_en, crystal_out_cap_en, clock_release, watchdog_tick;
    logic rd_pend_q = 1'b0;
    logic [7:0] exp_q[$];
    // Code in the high nibble, option fuse in bit 2, start-up code below
    // Internal RC rows keep the option fuse clear
    logic [7:0] cfgs [14] = '{8'h94, 8'h91, 8'h96, 8'h54, 8'h61, 8'h76, 8'h83,
        8'h10, 8'h21, 8'h33, 8'h42, 8'h04, 8'h01, 8'h06};
    int n_fail = 0;
    int num_checks = 0;

    clock_source_select #(.WDT_CYCLES_4MS(17'd4), .WDT_CYCLES_65MS(17'd8)) u_clock_source_select (
        .clock(clock), .sys_rst(sys_rst), .clock_select_fuses(clock_select_fuses),
        .startup_time_fuses(startup_time_fuses), .oscillator_option_fuse(oscillator_option_fuse),
        .fuses_virgin(fuses_virgin), .legacy_mode(legacy_mode),
        .calibration_byte(calibration_byte), .watchdog_osc(watchdog_osc),
        .wake_request(wake_request), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .trim_value(trim_value), .source_sel(source_sel), .rc_range(rc_range),
        .crystal_in_cap_en(crystal_in_cap_en), .crystal_out_cap_en(crystal_out_cap_en),
        .clock_release(clock_release), .watchdog_tick(watchdog_tick));
    watchdog_osc_model u_watchdog_osc_model (.osc_out(watchdog_osc));

    // 250 MHz core clock
    always #2 clock = ~clock;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic bail();
        check("wait bound", 32'h0, 32'h1);
        stop_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(v);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    // Read data stands one cycle after the strobe; oldest note is compared
    always @(posedge clock) begin
        if (rd_pend_q === 1'b1) begin
            check("read data", reg_rdata, exp_q.pop_front());
        end
        rd_pend_q <= reg_read;
    end

    // Reset with one fuse setting, then time the reset delay and one wake
    task automatic run_cfg(input logic v, input logic [7:0] cf);
        logic [3:0] c;
        logic [1:0] s;
        logic [7:0] cal;
        logic [2:0] src;
        logic rsv;
        int w, d, n, t;
        c = v ? `SEL_DEFAULT : cf[7:4];
        s = v ? `SUT_DEFAULT : cf[1:0];
        cal = 8'($urandom);
        w = 6;
        d = (s == 2'h0) ? 0 : (s == 2'h1) ? D4 : D65;
        src = (c == `SEL_EXT_CLOCK) ? clock_source_pkg::SRC_EXT_CLOCK : clock_source_pkg::SRC_INT_RC;
        if (c == `SEL_LF_CRYSTAL) begin
            src = clock_source_pkg::SRC_LF_CRYSTAL;
            w = (s == 2'h2) ? 32768 : 1024;
            d = (s == 2'h0) ? D4 : D65;
        end else if (c >= `SEL_EXT_RC_LO) begin
            src = clock_source_pkg::SRC_EXT_RC;
            w = (s == 2'h3) ? 6 : 18;
            d = (s == 2'h0) ? 0 : (s == 2'h2) ? D65 : D4;
        end
        rsv = (s == 2'h3) && !(c >= `SEL_EXT_RC_LO && c <= `SEL_EXT_RC_HI);
        @(posedge clock);
        sys_rst <= 1'b1;
        fuses_virgin <= v;
        clock_select_fuses <= cf[7:4];
        startup_time_fuses <= cf[1:0];
        oscillator_option_fuse <= cf[2];
        calibration_byte <= cal;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        n = 0;
        t = 0;
        while (clock_release !== 1'b1) begin
            @(posedge clock);
            n++;
            t += int'(watchdog_tick === 1'b1);
            if (n > 2000) bail();
        end
        check("reset delay", t >= d && t <= d + 1, 32'h1);
        check("source", source_sel, src);
        check("caps", {crystal_in_cap_en, crystal_out_cap_en}, {cf[2], cf[2] && c == 4'h9});
        if (c != `SEL_EXT_CLOCK && c != `SEL_LF_CRYSTAL) begin
            check("band", rc_range, 2'(c - 4'h1));
        end
        rd(`TRIM_OFFSET, cal);
        rd(`STATUS_OFFSET, {4'h0, 1'b1, cf[2], rsv, 1'b1});
        rd(`FUSE_OFFSET, {2'h0, s, c});
        @(posedge clock);
        wake_request <= 1'b1;
        @(posedge clock);
        wake_request <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n > 40000) bail();
        end while (clock_release !== 1'b1);
        check("wake length", n > w && n <= w + 3, 32'h1);
    endtask

    // Main sequence: each fuse setting in the table, blank fuses, then the trim register
    initial begin
        logic [7:0] vals [3];
        void'($urandom(92));
        foreach (cfgs[i]) begin
            run_cfg(1'b0, cfgs[i]);
        end
        run_cfg(1'b1, 8'($urandom) & 8'hfb);
        // Software loads its own trim; no memory write runs, so the full range is allowed
        vals = '{8'($urandom), 8'hff, 8'h00};
        foreach (vals[i]) begin
            wr(`TRIM_OFFSET, vals[i]);
            @(negedge clock);
            check("trim", trim_value, vals[i]);
            rd(`TRIM_OFFSET, vals[i]);
        end
        rd(8'h10, 8'h00);
        legacy_mode <= 1'b1;
        wr(`TRIM_OFFSET, 8'h5a);
        rd(`TRIM_OFFSET, 8'h00);
        legacy_mode <= 1'b0;
        rd(`TRIM_OFFSET, 8'h00);
        repeat (3) @(posedge clock);
        check("notes left", exp_q.size(), 32'h0);
        stop_test();
    end
endmodule

// *** dv/watchdog_osc_model.sv ***
// Purpose: Free-running watchdog oscillator feeding the block
// Assumes: Unrelated in phase to the core clock
// Notes: About nine core cycles per period
module watchdog_osc_model #(
    parameter real HALF_NS = 18.3
) (
    output logic osc_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Timer oscillator pins are left open here; they take only a watch crystal
    // Steady period; a jumping rate would make tick spacing meaningless
    initial begin
        osc_out = 1'b0;
        #1.3;
        forever #(HALF_NS) osc_out = ~osc_out;
    end
endmodule

// *** hw/clock_source_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the clock source block
// Assumes: 250 MHz core clock, trim register on a plain strobe port
// Notes: Times are kept in their own unit beside cycle counts given as literal constants
`ifndef CLOCK_SOURCE_CFG_SVH
`define CLOCK_SOURCE_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define TRIM_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define FUSE_OFFSET 8'h08

// ****************************************************************
// Fuse codes
// ****************************************************************
`define SEL_EXT_CLOCK 4'h0
`define SEL_INT_RC_1M 4'h1
`define SEL_INT_RC_8M 4'h4
`define SEL_EXT_RC_LO 4'h5
`define SEL_EXT_RC_HI 4'h8
`define SEL_LF_CRYSTAL 4'h9
`define SEL_DEFAULT 4'h1
`define SUT_DEFAULT 2'h2

// ****************************************************************
// Wake start-up counts in oscillator cycles
// ****************************************************************
`define WAKE_1K 16'd1024
`define WAKE_32K 16'd32768
`define WAKE_18 16'd18
`define WAKE_6 16'd6

// ****************************************************************
// Reset delays on the watchdog oscillator
// ****************************************************************
`define DELAY_4MS_US 4100
`define DELAY_65MS_US 65000
`define WDT_CYCLES_4MS 17'd4096
`define WDT_CYCLES_65MS 17'd65536

// Status bit positions
`define ST_RUN_BIT 0
`define ST_BAD_FUSE_BIT 1
`define ST_CAPS_BIT 2
`define ST_LOADED_BIT 3

`endif

// *** hw/clock_source_pkg.sv ***
// Purpose: Types shared by the clock source block
// Assumes: Constants live in clock_source_cfg.svh
// Notes: Only types here
package clock_source_pkg;
    typedef enum logic [2:0] {
        SRC_EXT_CLOCK,
        SRC_INT_RC,
        SRC_EXT_RC,
        SRC_LF_CRYSTAL,
        SRC_NONE
    } source_t;

    typedef enum logic [1:0] {
        ST_WAKE,
        ST_DELAY,
        ST_RUN
    } phase_t;
endpackage

// *** hw/clock_source_select.sv ***
// Purpose: Clock source decode, start-up timing and oscillator trim register
// Assumes: Fuses are stable pins; watchdog oscillator arrives as a pin level
// Notes: Analog oscillators stay outside; this block steers and times them
// Summary of operation
// - Fuse code 1001 picks the low-frequency watch crystal.
// - Option fuse with watch crystal turns on caps on both crystal pins.
// - Watch crystal: 1K/1K/32K wake cycles, 4.1/65/65 ms reset delay, 11 reserved.
// - Codes 0101 to 1000 are external RC, rising frequency ranges.
// - External RC: 18 cycles with none/4.1/65 ms; code 11 is 6 cycles plus 4.1 ms.
// - Option fuse with external RC or clock adds cap on clock input pin.
// - Codes 0001 to 0100 pick internal RC at 1, 2, 4, 8 MHz.
// - Internal RC: 6 cycles with none/4.1/65 ms; code 11 reserved.
// - Every reset loads the 1 MHz calibration byte into the trim register.
// - Watchdog and reset delay always run on the watchdog oscillator.
// - Trim zero is slowest, larger values faster, 0xff fastest.
// - Fuse code 0000 runs from an external clock on the clock pin.
// - External clock: 6 cycles with none/4.1/65 ms; code 11 reserved.
// - Legacy compatibility mode hides the trim register from software.
// - Default fuses give code 0001 with start-up code 10.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`include "clock_source_cfg.svh"

module clock_source_select #(
    parameter logic [16:0] WDT_CYCLES_4MS = `WDT_CYCLES_4MS,
    parameter logic [16:0] WDT_CYCLES_65MS = `WDT_CYCLES_65MS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] clock_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic oscillator_option_fuse,
    input wire logic fuses_virgin,
    input wire logic legacy_mode,
    input wire logic [7:0] calibration_byte,
    input wire logic watchdog_osc,
    input wire logic wake_request,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic [7:0] trim_value,
    output logic [2:0] source_sel,
    output logic [1:0] rc_range,
    output logic crystal_in_cap_en,
    output logic crystal_out_cap_en,
    output logic clock_release,
    output logic watchdog_tick
);
    logic [3:0] sel_eff;
    logic [1:0] sut_eff;
    clock_source_pkg::source_t source;
    logic reserved_code;
    logic [15:0] wake_count;
    logic [16:0] delay_count;
    clock_source_pkg::phase_t phase_q;
    logic after_reset_q;
    logic wdt_sync;
    logic wdt_prev_q;
    logic wake_load;
    logic wake_done;
    logic delay_load;
    logic delay_done;
    logic loaded_q;
    logic [7:0] trim_q;
    logic [7:0] status_word;

    initial begin
        if (WDT_CYCLES_4MS == 17'd0)
            $error("short reset delay count is zero");
        if (WDT_CYCLES_65MS < WDT_CYCLES_4MS)
            $error("reset delay counts out of order");
    end

    // ****************************************************************
    // Fuse decode
    // ****************************************************************
    // Blank fuses fall back to the shipped default
    // The default replaces the fuses before decode, so the fuse readback shows the code in use
    assign sel_eff = fuses_virgin ? `SEL_DEFAULT : clock_select_fuses;
    assign sut_eff = fuses_virgin ? `SUT_DEFAULT : startup_time_fuses;

    // Source and counts per fuse code; reserved codes take the 65 ms delay and 32K wake, or 6 wake cycles under external clock and internal RC
    // Reserved codes also raise a status flag so software can spot a bad setting
    always_comb begin
        source = clock_source_pkg::SRC_NONE;
        reserved_code = 1'b0;
        wake_count = `WAKE_32K;
        delay_count = WDT_CYCLES_65MS;
        if (sel_eff == `SEL_EXT_CLOCK) begin
            source = clock_source_pkg::SRC_EXT_CLOCK;
            wake_count = `WAKE_6;
            case (sut_eff)
                2'h0: delay_count = 17'd0;
                2'h1: delay_count = WDT_CYCLES_4MS;
                2'h2: delay_count = WDT_CYCLES_65MS;
                default: reserved_code = 1'b1;
            endcase
        end else if (sel_eff <= `SEL_INT_RC_8M) begin
            source = clock_source_pkg::SRC_INT_RC;
            wake_count = `WAKE_6;
            case (sut_eff)
                2'h0: delay_count = 17'd0;
                2'h1: delay_count = WDT_CYCLES_4MS;
                2'h2: delay_count = WDT_CYCLES_65MS;
                default: reserved_code = 1'b1;
            endcase
        end else if (sel_eff <= `SEL_EXT_RC_HI) begin
            source = clock_source_pkg::SRC_EXT_RC;
            wake_count = `WAKE_18;
            case (sut_eff)
                2'h0: delay_count = 17'd0;
                2'h1: delay_count = WDT_CYCLES_4MS;
                2'h2: delay_count = WDT_CYCLES_65MS;
                default: begin
                    wake_count = `WAKE_6;
                    delay_count = WDT_CYCLES_4MS;
                end
            endcase
        end else if (sel_eff == `SEL_LF_CRYSTAL) begin
            source = clock_source_pkg::SRC_LF_CRYSTAL;
            case (sut_eff)
                2'h0: begin
                    wake_count = `WAKE_1K;
                    delay_count = WDT_CYCLES_4MS;
                end
                2'h1: begin
                    wake_count = `WAKE_1K;
                    delay_count = WDT_CYCLES_65MS;
                end
                2'h2: begin
                    wake_count = `WAKE_32K;
                    delay_count = WDT_CYCLES_65MS;
                end
                default: reserved_code = 1'b1;
            endcase
        end else begin
            reserved_code = 1'b1;
        end
    end

    // Range within RC families; internal RC 1,2,4,8 MHz and external RC four bands
    // Outside the two RC families the band output idles at zero
    always_comb begin
        rc_range = 2'h0;
        if (source == clock_source_pkg::SRC_INT_RC)
            rc_range = 2'(sel_eff - `SEL_INT_RC_1M);
        else if (source == clock_source_pkg::SRC_EXT_RC)
            rc_range = 2'(sel_eff - `SEL_EXT_RC_LO);
    end

    // ****************************************************************
    // Pin capacitor and source outputs
    // ****************************************************************
    // Registered so pad controls never glitch while fuses settle
    // Internal RC never gets a cap, whatever the option fuse holds
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            source_sel <= 3'(clock_source_pkg::SRC_INT_RC);
            crystal_in_cap_en <= 1'b0;
            crystal_out_cap_en <= 1'b0;
        end else begin
            source_sel <= 3'(source);
            crystal_in_cap_en <= oscillator_option_fuse &&
                (source == clock_source_pkg::SRC_LF_CRYSTAL ||
                 source == clock_source_pkg::SRC_EXT_RC ||
                 source == clock_source_pkg::SRC_EXT_CLOCK);
            crystal_out_cap_en <= oscillator_option_fuse &&
                (source == clock_source_pkg::SRC_LF_CRYSTAL);
        end
    end

    // ****************************************************************
    // Watchdog oscillator tick
    // ****************************************************************
    pulse_sync u_wdt_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(watchdog_osc),
        .sync_out(wdt_sync)
    );

    // Rising edge of the synchronised watchdog level times the reset delay
    // Only the second synchroniser stage is read; the first may be metastable
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            wdt_prev_q <= 1'b0;
        else
            wdt_prev_q <= wdt_sync;
    end
    assign watchdog_tick = wdt_sync && !wdt_prev_q;

    // ****************************************************************
    // Start-up sequence
    // ****************************************************************
    // A wake request only counts in RUN; one during start-up is ignored
    // The reset delay is loaded once, in the cycle the wake count finishes
    assign wake_load = (phase_q == clock_source_pkg::ST_RUN) && wake_request;
    assign delay_load = (phase_q == clock_source_pkg::ST_WAKE) && wake_done && after_reset_q;

    cycle_counter #(.WIDTH(17)) u_wake (
        .clock(clock),
        .sys_rst(sys_rst),
        .load(wake_load),
        .load_value({1'b0, wake_count}),
        .tick(phase_q == clock_source_pkg::ST_WAKE),
        .done(wake_done)
    );

    cycle_counter #(.WIDTH(17)) u_delay (
        .clock(clock),
        .sys_rst(sys_rst),
        .load(delay_load),
        .load_value(delay_count),
        .tick(watchdog_tick),
        .done(delay_done)
    );

    // Reset starts in wake with the wake counter already done
    // A request in RUN restarts the wake count; after reset the delay follows
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= clock_source_pkg::ST_WAKE;
            after_reset_q <= 1'b1;
        end else begin
            case (phase_q)
                clock_source_pkg::ST_WAKE: begin
                    if (wake_done && after_reset_q)
                        phase_q <= clock_source_pkg::ST_DELAY;
                    else if (wake_done)
                        phase_q <= clock_source_pkg::ST_RUN;
                end
                clock_source_pkg::ST_DELAY: begin
                    if (delay_done && !delay_load) begin
                        phase_q <= clock_source_pkg::ST_RUN;
                        after_reset_q <= 1'b0;
                    end
                end
                clock_source_pkg::ST_RUN: begin
                    if (wake_request)
                        phase_q <= clock_source_pkg::ST_WAKE;
                end
                default: phase_q <= clock_source_pkg::ST_WAKE;
            endcase
        end
    end

    // Counter is idle-done after reset, so the first wake after reset is
    // only one cycle long; the reset delay on the watchdog clock dominates.
    assign clock_release = (phase_q == clock_source_pkg::ST_RUN);

    // ****************************************************************
    // Trim register
    // ****************************************************************
    // First clocked edge after release catches the calibration byte
    // Writes in the loading cycle are dropped so the calibration byte always wins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            trim_q <= 8'h00;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            trim_q <= calibration_byte;
            loaded_q <= 1'b1;
        end else if (reg_write && reg_addr == `TRIM_OFFSET && !legacy_mode) begin
            trim_q <= reg_wdata;
        end
    end
    assign trim_value = trim_q;

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Status word: release, reserved fuse code, input cap, calibration loaded
    always_comb begin
        status_word = 8'h00;
        status_word[`ST_RUN_BIT] = clock_release;
        status_word[`ST_BAD_FUSE_BIT] = reserved_code;
        status_word[`ST_CAPS_BIT] = crystal_in_cap_en;
        status_word[`ST_LOADED_BIT] = loaded_q;
    end

    // Data stand one cycle after the strobe; unmapped and hidden read zero
    // Hidden trim reads zero, so legacy software finds an empty address
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `TRIM_OFFSET: reg_rdata <= legacy_mode ? 8'h00 : trim_q;
                `STATUS_OFFSET: reg_rdata <= status_word;
                `FUSE_OFFSET: reg_rdata <= {2'h0, sut_eff, sel_eff};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// *** hw/cycle_counter.sv ***
// Purpose: Loadable down counter with done flag
// Assumes: Load and tick on the same clock
// Notes: Done stays high until the next load
module cycle_counter #(
    parameter int WIDTH = 17
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic tick,
    output logic done
);
    logic [WIDTH-1:0] count_q;

    initial begin
        if (WIDTH < 2) $error("cycle_counter width too small");
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Zero load finishes at once, so an absent delay costs no time
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
            // Done out of reset, so an idle counter never runs down from zero
            done <= 1'b1;
        end else if (load) begin
            count_q <= load_value;
            done <= (load_value == '0);
        end else if (tick && !done) begin
            count_q <= count_q - 1'b1;
            done <= (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
endmodule

// *** hw/pulse_sync.sv ***
// Purpose: Two-flop level synchroniser
// Assumes: Asynchronous level input
// Notes: First flop feeds only the second
module pulse_sync (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // ****************************************************************
    // Synchroniser
    // ****************************************************************
    // Two stages keep metastability out of the decode logic
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
